/* File: pkg/bfc_pkg.sv */
// constants, enumerations and timing counts of the beacon flash controller
// assumes a single free-running 25 MHz system clock
package bfc_pkg;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int unsigned CLK_HZ      = 25_000_000;
   localparam int unsigned TICK_MS     = 10;
   localparam int unsigned TICK_CYCLES = TICK_MS * (CLK_HZ / 1000);
   localparam int unsigned DEB_MS      = 20;
   localparam logic [1:0]  DEB_TICKS   = 2'(DEB_MS / TICK_MS);
   localparam int unsigned LONG_MS     = 1000;
   localparam logic [6:0]  LONG_TICKS  = 7'(LONG_MS / TICK_MS);
   localparam logic [6:0]  SEC_TICKS   = 7'(1000 / TICK_MS);
   localparam logic [6:0]  HALF_TICKS  = 7'(500 / TICK_MS);
   localparam logic [6:0]  PULSE1_TICKS = 7'(100 / TICK_MS);
   localparam logic [6:0]  PULSE25_TICKS = 7'(250 / TICK_MS);
   localparam logic [6:0]  CONF_TICKS  = 7'(250 / TICK_MS);
   localparam logic [2:0]  CONF_HALVES = 3'h6;
   // ----------------------------------------
   // duration index table
   // ----------------------------------------
   localparam logic [11:0] DUR_MIN_S   = 12'h005;
   localparam logic [6:0]  DUR_FINE_N  = 7'h38;
   localparam logic [6:0]  DUR_MIN_N   = 7'h4b;
   localparam logic [11:0] DUR_HOUR_S  = 12'he10;
   localparam logic [11:0] DUR_STEP_S  = 12'h03c;
   localparam logic [7:0]  DUR_RST     = 8'h0f;
   // ----------------------------------------
   // settings
   // ----------------------------------------
   typedef enum logic [3:0] {
      PAT_WWS     = 4'h0, PAT_WWS_LEG = 4'h1, PAT_WWS_2  = 4'h2,
      PAT_UNI_05  = 4'h3, PAT_ALT_05  = 4'h4, PAT_ALT_3B = 4'h5,
      PAT_UNI_01  = 4'h6, PAT_UNI_025 = 4'h7, PAT_QUICK_U = 4'h8,
      PAT_QUICK_A = 4'h9, PAT_STEADY  = 4'ha
   } bfc_pat_t;
   typedef enum logic [1:0] {
      IN_MOMENTARY = 2'h0, IN_OPEN_LEVEL = 2'h1, IN_CLOSED_LEVEL = 2'h2, IN_NIGHT = 2'h3
   } bfc_in_t;
   typedef enum logic [1:0] {
      BATT_OK = 2'h0, BATT_LOW = 2'h1, BATT_CUTOFF = 2'h2
   } bfc_batt_t;
   localparam logic [7:0] PAT_RST = 8'h04;
   localparam logic [7:0] IN_RST  = 8'h00;
   // ----------------------------------------
   // menu items
   // ----------------------------------------
   localparam logic [4:0] IT_FAULT = 5'h00, IT_BATT = 5'h01, IT_SOLAR = 5'h02;
   localparam logic [4:0] IT_PAT = 5'h03, IT_INPUT = 5'h04, IT_DUR = 5'h05;
   localparam logic [4:0] IT_DIM = 5'h07, IT_AMB = 5'h08, IT_RDET = 5'h0e;
   localparam logic [4:0] IT_DOUT = 5'h0f, IT_PBST = 5'h10, IT_FW = 5'h13;
   localparam logic [4:0] IT_LAST = 5'h13;
endpackage : bfc_pkg

/* File: hw/bfc_top.sv */
// beacon flash controller: front panel menu, pattern generator, activation, fault
// assumes synchronous active-high button and contact levels and per-bank load sense
`timescale 1ns/1ps
module bfc_top
   import bfc_pkg::*;
#(
   parameter int unsigned TICK_CYC = bfc_pkg::TICK_CYCLES,
   parameter logic [7:0]  FW_VER   = 8'h11          // arbitrary value
)(
   input  wire  logic       mclk,
   input  wire  logic       rst_b,
   input  wire  logic       btn_up,
   input  wire  logic       btn_dn,
   input  wire  logic       btn_set,
   input  wire  logic       contact_closed,
   input  wire  logic       is_night,
   input  wire  logic       batt_low,
   input  wire  logic       batt_cutoff,
   input  wire  logic       load_sense_b1,
   input  wire  logic       load_sense_b2,
   input  wire  logic       load_short,
   input  wire  logic [3:0] fixture_count,
   input  wire  logic       light_bar,
   output logic             bank1_on_r,
   output logic             bank2_on_r,
   output logic             digital_out_r,
   output logic             flashing_r,
   output logic             fixture_open_fault_r,
   output bfc_pkg::bfc_batt_t batt_state_r,
   output logic             night_r,
   output logic [4:0]       disp_item_r,
   output logic [7:0]       disp_value_r,
   output logic             disp_blink_r,
   output logic             disp_blank_r,
   output logic             bcast_r,
   output logic [4:0]       bcast_item_r,
   output logic [7:0]       bcast_value_r
);
   import bfc_pkg::*;

   // ----------------------------------------
   // tick and debounce
   // ----------------------------------------
   logic [31:0] div_r;
   logic        tick;
   assign tick = (div_r == 32'(TICK_CYC - 1));
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) div_r <= '0;
      else        div_r <= tick ? '0 : div_r + 32'h1;
   end

   logic [3:0] raw, db_r, db_prev_r;
   assign raw = {contact_closed, btn_set, btn_dn, btn_up};
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_deb
         logic [1:0] cnt_r;
         always_ff @(posedge mclk or negedge rst_b) begin
            if (!rst_b) begin
               cnt_r       <= '0;
               db_r[gi]    <= 1'b0;
            end else if (raw[gi] == db_r[gi]) begin
               cnt_r <= '0;
            end else if (tick) begin
               cnt_r <= cnt_r + 2'h1;
               if (cnt_r + 2'h1 >= DEB_TICKS) db_r[gi] <= raw[gi];
            end
         end
      end
   endgenerate
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) db_prev_r <= '0;
      else        db_prev_r <= db_r;
   end
   logic up_p, dn_p, contact_rise;
   assign up_p         = db_r[0] & ~db_prev_r[0];
   assign dn_p         = db_r[1] & ~db_prev_r[1];
   assign contact_rise = db_r[3] & ~db_prev_r[3];

   logic [6:0] hold_r;
   logic       long_p;
   // one second hold, one pulse per hold
   assign long_p = tick & db_r[2] & (hold_r == LONG_TICKS - 7'h1);
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b)               hold_r <= '0;
      else if (!db_r[2])        hold_r <= '0;
      else if (tick && hold_r != LONG_TICKS) hold_r <= hold_r + 7'h1;
   end

   // ----------------------------------------
   // settings store and menu
   // ----------------------------------------
   logic [7:0] val_r [0:19];
   logic [7:0] pend_r;
   logic       edit_r;
   logic [2:0] conf_half_r;
   logic [6:0] conf_cnt_r;

   function automatic logic [7:0] max_val(input logic [4:0] it);
      case (it)
         IT_PAT:                 max_val = 8'(PAT_STEADY);
         IT_INPUT:               max_val = 8'h03;
         IT_DUR:                 max_val = 8'(DUR_MIN_N);
         IT_DIM, IT_AMB, IT_DOUT: max_val = 8'h01;
         default:                max_val = 8'hff;
      endcase
   endfunction : max_val

   function automatic logic [7:0] rst_val(input int i);
      case (i)
         3:       rst_val = PAT_RST;
         4:       rst_val = IN_RST;
         5:       rst_val = DUR_RST;
         default: rst_val = 8'h00;
      endcase
   endfunction : rst_val

   logic adjustable, is_bcast, fault_gone;
   logic [4:0] item_up, item_dn, item_nxt;
   assign adjustable = (disp_item_r >= IT_PAT) && (disp_item_r < IT_FW) &&
                       (disp_item_r != IT_RDET) && (disp_item_r != IT_PBST);
   assign is_bcast   = (disp_item_r == IT_DUR) || (disp_item_r == IT_DIM) || (disp_item_r == IT_AMB);
   // fault item skipped unless a fault is held
   assign item_up    = (disp_item_r == IT_LAST) ? (fixture_open_fault_r ? IT_FAULT : IT_BATT)
                                                : disp_item_r + 5'h1;
   assign item_dn    = (disp_item_r == IT_BATT && !fixture_open_fault_r) ? IT_LAST
                     : (disp_item_r == IT_FAULT) ? IT_LAST : disp_item_r - 5'h1;
   assign fault_gone = (disp_item_r == IT_FAULT) && !fixture_open_fault_r;
   // step through items one at a time
   assign item_nxt   = fault_gone ? IT_BATT : (up_p ? item_up : (dn_p ? item_dn : disp_item_r));

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < 20; i++) val_r[i] <= rst_val(i);
         disp_item_r <= IT_BATT;
         edit_r      <= 1'b0;
         pend_r      <= '0;
         bcast_r     <= 1'b0;
         bcast_item_r  <= '0;
         bcast_value_r <= '0;
      end else begin
         bcast_r <= 1'b0;
         if (!edit_r) begin
            disp_item_r <= item_nxt;
            // long press enters edit on adjustable item
            if (long_p && adjustable) begin
               edit_r <= 1'b1;
               pend_r <= val_r[disp_item_r];
            end
         end else if (long_p) begin
            edit_r               <= 1'b0;
            val_r[disp_item_r]   <= pend_r;
            bcast_r              <= is_bcast;
            bcast_item_r         <= disp_item_r;
            bcast_value_r        <= pend_r;
         end else if (up_p && pend_r < max_val(disp_item_r)) begin
            pend_r <= pend_r + 8'h1;
         end else if (dn_p && pend_r != 8'h00) begin
            pend_r <= pend_r - 8'h1;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         conf_half_r <= '0;
         conf_cnt_r  <= '0;
      end else if (edit_r && long_p) begin
         conf_half_r <= CONF_HALVES;
         conf_cnt_r  <= '0;
      end else if (tick && conf_half_r != 3'h0) begin
         conf_cnt_r <= (conf_cnt_r == CONF_TICKS - 7'h1) ? 7'h0 : conf_cnt_r + 7'h1;
         if (conf_cnt_r == CONF_TICKS - 7'h1) conf_half_r <= conf_half_r - 3'h1;
      end
   end

   logic [7:0] shown;
   assign shown = edit_r                     ? pend_r
                : (disp_item_r == IT_FAULT)  ? {7'h0, fixture_open_fault_r}
                : (disp_item_r == IT_BATT)   ? {6'h0, batt_state_r}
                : (disp_item_r == IT_SOLAR)  ? {7'h0, night_r}
                : (disp_item_r == IT_PBST)   ? {7'h0, db_r[3]}
                : (disp_item_r == IT_FW)     ? FW_VER
                : (disp_item_r == IT_RDET)   ? 8'h00 : val_r[disp_item_r];
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         disp_value_r <= '0;
         disp_blink_r <= 1'b0;
         disp_blank_r <= 1'b0;
      end else begin
         disp_value_r <= shown;
         disp_blink_r <= edit_r;
         disp_blank_r <= conf_half_r[0];
      end
   end

   // ----------------------------------------
   // battery, night and activation
   // ----------------------------------------
   bfc_pat_t pat;
   bfc_in_t  in_type;
   assign pat     = bfc_pat_t'(val_r[IT_PAT][3:0]);
   assign in_type = bfc_in_t'(val_r[IT_INPUT][1:0]);

   function automatic logic [11:0] dur_secs(input logic [7:0] idx);
      if (idx[6:0] < DUR_FINE_N)      dur_secs = DUR_MIN_S + 12'(idx);
      else if (idx[6:0] < DUR_MIN_N)  dur_secs = 12'(12'(idx - 8'h36) * DUR_STEP_S);
      else                            dur_secs = DUR_HOUR_S;
   endfunction : dur_secs

   logic [11:0] rem_s_r;
   logic [6:0]  sub_r;
   logic        active, go;
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rem_s_r <= '0;
         sub_r   <= '0;
      end else if (contact_rise && in_type == IN_MOMENTARY) begin
         rem_s_r <= dur_secs(val_r[IT_DUR]);
         sub_r   <= '0;
      end else if (tick && rem_s_r != 12'h0) begin
         sub_r <= (sub_r == SEC_TICKS - 7'h1) ? 7'h0 : sub_r + 7'h1;
         if (sub_r == SEC_TICKS - 7'h1) rem_s_r <= rem_s_r - 12'h1;
      end
   end

   always_comb begin
      case (in_type)
         // brief closure runs the duration timer
         IN_MOMENTARY:    active = (rem_s_r != 12'h0);
         IN_OPEN_LEVEL:   active = db_r[3];
         IN_CLOSED_LEVEL: active = ~db_r[3];
         IN_NIGHT:        active = night_r;
         default:         active = 1'b0;
      endcase
   end
   assign go = active && (batt_state_r != BATT_CUTOFF);

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         batt_state_r <= BATT_OK;
         night_r      <= 1'b0;
      end else begin
         batt_state_r <= batt_cutoff ? BATT_CUTOFF : (batt_low ? BATT_LOW : BATT_OK);
         night_r      <= is_night;
      end
   end

   // ----------------------------------------
   // pattern generator
   // ----------------------------------------
   logic [6:0] ph_r;
   logic [3:0] seg, seg_leg;
   logic       b1, b2;
   assign seg     = 4'(ph_r / PULSE1_TICKS);
   assign seg_leg = ph_r[6:3];
   // phase held at zero while idle
   // so the bank registers see phase zero on the very first active edge
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b)                 ph_r <= '0;
      else if (!go)               ph_r <= '0;
      else if (tick)              ph_r <= (ph_r == SEC_TICKS - 7'h1) ? 7'h0 : ph_r + 7'h1;
   end

   // wig-wag then both-on inside each second; the legacy variant runs shorter 80 ms steps
   always_comb begin
      b1 = 1'b0;
      b2 = 1'b0;
      case (pat)
         PAT_WWS: begin
            b1 = (seg == 4'h0) || (seg == 4'h2) || (seg == 4'h4) || (seg == 4'h6);
            b2 = (seg == 4'h1) || (seg == 4'h3) || (seg == 4'h4) || (seg == 4'h6);
         end
         PAT_WWS_LEG: begin
            b1 = (seg_leg == 4'h0) || (seg_leg == 4'h2) || (seg_leg == 4'h4) || (seg_leg == 4'h6);
            b2 = (seg_leg == 4'h1) || (seg_leg == 4'h3) || (seg_leg == 4'h4) || (seg_leg == 4'h6);
         end
         PAT_WWS_2: begin
            b1 = (seg == 4'h0) || (seg == 4'h2) || (seg == 4'h4) || (seg == 4'h5);
            b2 = (seg == 4'h1) || (seg == 4'h3) || (seg == 4'h4) || (seg == 4'h5);
         end
         // both on for the first half second
         PAT_UNI_05: begin
            b1 = (ph_r < HALF_TICKS);
            b2 = (ph_r < HALF_TICKS);
         end
         PAT_ALT_05, PAT_ALT_3B: begin
            b1 = (ph_r < HALF_TICKS);
            b2 = (ph_r >= HALF_TICKS);
         end
         PAT_UNI_01: begin
            b1 = (ph_r < PULSE1_TICKS);
            b2 = (ph_r < PULSE1_TICKS);
         end
         PAT_UNI_025: begin
            b1 = (ph_r < PULSE25_TICKS);
            b2 = (ph_r < PULSE25_TICKS);
         end
         // three 0.1 s pulses per burst
         PAT_QUICK_U: begin
            b1 = (seg < 4'h5) && !seg[0];
            b2 = (seg < 4'h5) && !seg[0];
         end
         PAT_QUICK_A: begin
            b1 = (seg < 4'h5) && !seg[0];
            b2 = (seg >= 4'h5) && seg[0];
         end
         // bank one held on, bank two unused
         PAT_STEADY: b1 = 1'b1;
         default: ;
      endcase
   end

   // single driver, bank selects from pattern
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         bank1_on_r    <= 1'b0;
         bank2_on_r    <= 1'b0;
         digital_out_r <= 1'b0;
         flashing_r    <= 1'b0;
      end else begin
         bank1_on_r    <= go & b1;
         bank2_on_r    <= go & b2;
         // digital output forced off in cutoff
         digital_out_r <= go & val_r[IT_DOUT][0];
         flashing_r    <= go;
      end
   end

   // ----------------------------------------
   // fixture fault
   // ----------------------------------------
   logic unison, open_chk, fault_now, seen_r;
   assign unison   = (pat == PAT_UNI_05) || (pat == PAT_UNI_01) || (pat == PAT_UNI_025) ||
                     (pat == PAT_QUICK_U) || (pat == PAT_STEADY);
   // open check only for small setups
   assign open_chk = !(unison && (fixture_count > 4'h1 || light_bar)) &&
                     !(fixture_count > 4'h2) && !(light_bar && fixture_count > 4'h1);
   // driven bank with no load counts as open; sampled on ticks so the driver settles
   assign fault_now = tick && flashing_r && (load_short ||
                      (open_chk && ((bank1_on_r && !load_sense_b1) || (bank2_on_r && !load_sense_b2))));
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         fixture_open_fault_r <= 1'b0;
         seen_r               <= 1'b0;
      end else begin
         if (go && !flashing_r) seen_r <= fault_now;
         else if (fault_now)    seen_r <= 1'b1;
         // clear only after a clean activation; a new fault wins
         if (fault_now)                             fixture_open_fault_r <= 1'b1;
         else if (!go && flashing_r && !seen_r)     fixture_open_fault_r <= 1'b0;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);

   property p_cutoff_dark;
      batt_cutoff |=> ##1 (!bank1_on_r && !bank2_on_r && !digital_out_r);
   endproperty
   a_cutoff_dark: assert property (p_cutoff_dark) else $error("flash during cutoff");
   property p_edit_blink;
      (!edit_r && long_p && adjustable) |=> ##1 disp_blink_r;
   endproperty
   a_edit_blink: assert property (p_edit_blink) else $error("no blink in edit");
   sequence s_commit; edit_r && long_p; endsequence
   sequence s_flash; ##[1:2] conf_half_r == CONF_HALVES; endsequence
   property p_commit_flash;
      s_commit |-> s_flash;
   endproperty
   a_commit_flash: assert property (p_commit_flash) else $error("no confirm flash");
   property p_fault_hidden;
      (!fixture_open_fault_r && disp_item_r != IT_FAULT) |=> disp_item_r != IT_FAULT;
   endproperty
   a_fault_hidden: assert property (p_fault_hidden) else $error("fault item shown");
   property p_steady;
      (pat == PAT_STEADY && go) |=> bank1_on_r && !bank2_on_r;
   endproperty
   a_steady: assert property (p_steady) else $error("steady pattern wrong");
   property p_unison;
      (pat == PAT_UNI_05 || pat == PAT_UNI_01) |=> bank1_on_r == bank2_on_r;
   endproperty
   a_unison: assert property (p_unison) else $error("unison banks differ");
   property p_alt;
      (pat == PAT_ALT_05 && $stable(pat)) |=> !(bank1_on_r && bank2_on_r);
   endproperty
   a_alt: assert property (p_alt) else $error("alternating banks overlap");
   property p_bcast;
      bcast_r |-> (bcast_item_r == IT_DUR || bcast_item_r == IT_DIM || bcast_item_r == IT_AMB);
   endproperty
   a_bcast: assert property (p_bcast) else $error("local item broadcast");
   property p_night;
      (in_type == IN_NIGHT && !night_r && $stable(in_type)) |=> !flashing_r;
   endproperty
   a_night: assert property (p_night) else $error("flashing by day");
endmodule : bfc_top

/* File: sim/bfc_fixture_model.sv */
// fixture load model: a bank draws current only if a fixture is fitted on it
// assumes bank controls are registered levels from the controller
`timescale 1ns/1ps
module bfc_fixture_model (
   input  wire logic bank1_on,
   input  wire logic bank2_on,
   input  wire logic fit1,
   input  wire logic fit2,
   output logic      load_sense_b1,
   output logic      load_sense_b2
);
   assign load_sense_b1 = bank1_on & fit1;
   assign load_sense_b2 = bank2_on & fit2;
endmodule : bfc_fixture_model

/* File: sim/bfc_top_tb.sv */
// self-checking bench for the beacon flash controller
// assumes a short tick (10 clocks) so durations fit the run
`timescale 1ns/1ps
module bfc_top_tb;
   import bfc_pkg::*;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic mclk = 0, rst_b = 0, up = 0, dn = 0, st = 0, cc = 0, night = 0;
   logic blow = 0, bcut = 0, fit1 = 1, fit2 = 1, ls1, ls2;
   logic b1, b2, dout, fl, flt, ngt, blink, blank, bc;
   logic [1:0] bst;
   logic [4:0] item, bci;
   logic [7:0] val, bcv;
   int n_errors = 0, samples_checked = 0;
   int n_bcast = 0;
   always #20 mclk = ~mclk;
   // broadcast is a one-cycle pulse, so count it as it happens
   always @(posedge mclk) if (bc === 1'b1) n_bcast <= n_bcast + 1;
   bfc_top #(.TICK_CYC(10)) uut (.mclk(mclk), .rst_b(rst_b), .btn_up(up), .btn_dn(dn),
      .btn_set(st), .contact_closed(cc), .is_night(night), .batt_low(blow), .batt_cutoff(bcut),
      .load_sense_b1(ls1), .load_sense_b2(ls2), .load_short(1'b0), .fixture_count(4'h2),
      .light_bar(1'b0), .bank1_on_r(b1), .bank2_on_r(b2), .digital_out_r(dout), .flashing_r(fl),
      .fixture_open_fault_r(flt), .batt_state_r(bst), .night_r(ngt), .disp_item_r(item),
      .disp_value_r(val), .disp_blink_r(blink), .disp_blank_r(blank), .bcast_r(bc),
      .bcast_item_r(bci), .bcast_value_r(bcv));
   bfc_fixture_model fix (.bank1_on(b1), .bank2_on(b2), .fit1(fit1), .fit2(fit2),
      .load_sense_b1(ls1), .load_sense_b2(ls2));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic stop_test;
      if (n_errors == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : stop_test
   task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
      samples_checked++;
      if (g !== e) begin
         n_errors++;
         $display("BAD %0t %s got %h want %h", $time, m, g, e);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : cyc
   // press: 0 up, 1 down, 2 set; hold counted in ticks
   task automatic press(input int w, input int ticks);
      if (w == 0) up = 1; else if (w == 1) dn = 1; else st = 1;
      cyc(ticks * 10);
      up = 0;
      dn = 0;
      st = 0;
      cyc(60);
   endtask : press
   // set held past the one-second long press
   task automatic hold_set;
      st = 1;
      cyc(1040);
      st = 0;
      cyc(5);
   endtask : hold_set
   task automatic wait_fl(input logic v, input int n);
      for (int i = 0; i < n && fl !== v; i++) cyc(1);
      chk(fl, v, "flashing");
   endtask : wait_fl
   task automatic pulse_contact;
      cc = 1;
      cyc(50);
      cc = 0;
   endtask : pulse_contact
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset;
      chk(item, 8'h01, "reset item");
      chk(bst, 8'h00, "reset batt");
      chk({b1, b2, dout, flt}, 8'h00, "reset outs");
   endtask : t_reset
   task automatic t_alternate;
      pulse_contact();
      wait_fl(1, 100);
      cyc(250);
      chk({b1, b2}, 8'h02, "first half");
      cyc(500);
      chk({b1, b2}, 8'h01, "second half");
      fit2 = 0;
      cyc(1000);
      chk(flt, 8'h01, "open fault");
      press(1, 5);
      chk(item, IT_FAULT, "fault item shown");
      chk(val, 8'h01, "fault item value");
      wait_fl(0, 25000);
      fit2 = 1;
      pulse_contact();
      wait_fl(1, 100);
      // default index is 20 s, 1000 clocks a second with the short tick
      cyc(19900);
      chk(fl, 8'h01, "still flashing");
      wait_fl(0, 150);
      chk(flt, 8'h00, "fault cleared");
      cyc(2);
      chk(item, 8'h01, "fault item gone");
   endtask : t_alternate
   task automatic t_menu_edit;
      press(0, 5);
      chk(item, 8'h02, "step up");
      repeat (3) press(0, 5);
      chk(item, IT_DUR, "at duration");
      hold_set();
      chk(blink, 8'h01, "edit blink");
      press(1, 5);
      chk(val, DUR_RST - 8'h1, "pending duration");
      hold_set();
      chk(blink, 8'h00, "committed");
      chk(8'(n_bcast), 8'h01, "duration broadcast");
      chk(bci, IT_DUR, "broadcast item");
      chk(bcv, DUR_RST - 8'h1, "broadcast value");
      press(1, 5);
      chk(item, IT_INPUT, "at input");
      hold_set();
      press(0, 5);
      chk(val, IN_OPEN_LEVEL, "pending input");
      hold_set();
      for (int i = 0; i < 300 && blank !== 1'b1; i++) cyc(1);
      chk(blank, 8'h01, "confirm flash");
      chk(8'(n_bcast), 8'h01, "input kept local");
      press(1, 5);
      hold_set();
      press(1, 5);
      hold_set();
      chk(val, 8'(PAT_UNI_05), "unison pattern");
      repeat (7) press(1, 5);
      chk(item, IT_DOUT, "wrap past hidden fault");
      hold_set();
      press(0, 5);
      hold_set();
      chk(val, 8'h01, "digital output on");
   endtask : t_menu_edit
   task automatic t_level_batt;
      cc = 1;
      wait_fl(1, 100);
      fit2 = 0;
      cyc(250);
      chk({b1, b2, dout}, 8'h07, "unison on");
      cyc(500);
      chk({b1, b2, dout}, 8'h01, "unison off");
      chk(flt, 8'h00, "no open check in unison");
      fit2 = 1;
      bcut = 1;
      cyc(3);
      chk({bst, b1, b2, dout, fl}, 8'h20, "cutoff");
      bcut = 0;
      blow = 1;
      cyc(20);
      chk({bst, fl}, 8'h03, "low warn");
      night = 1;
      cyc(50);
      chk(ngt, 8'h01, "night");
      cc = 0;
      wait_fl(0, 100);
   endtask : t_level_batt
   // ----------------------------------------
   // main sequence and watchdog
   // ----------------------------------------
   initial begin
      cyc(4);
      t_reset();
      rst_b = 1;
      cyc(5);
      t_alternate();
      t_menu_edit();
      t_level_batt();
      stop_test();
   end
   initial begin
      repeat (90000) @(posedge mclk);
      n_errors++;
      stop_test();
   end
endmodule : bfc_top_tb
